//--- dv/pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_src (
  // Clock.
  input  wire logic clk,
  // Pin toward the timer.
  output logic      pin
);
  initial pin = 1'b0;

  // Drives one high pulse, then holds the pin low and steady.
  task automatic pulse(input int hi, input int lo);
    @(posedge clk);
    pin <= 1'b1;
    repeat (hi) @(posedge clk);
    pin <= 1'b0;
    repeat (lo) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cfg.svh"
module tb;
  import timer16_pkg::*;
  logic        clk, rst, wr, rd, rd_q, pin, tpin, pirq, sirq;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, v, v2;
  logic [31:0] seed;
  logic [15:0] exp_q[$];
  int          n_fail, num_checks, n_pirq, n_sirq, w, n;
  edge_sel_e   codes[4] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH, EDGE_BAD};
  int          mult[4]  = '{1, 1, 2, 0};

  timer16_capture_event_oneshot #(.DIV0(1)) i_dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .trigger_input_pin(pin), .timer_output_pin(tpin),
    .period_match_irq(pirq), .secondary_match_irq(sirq));
  pulse_src i_src (.clk(clk), .pin(pin));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic rd_val(input logic [7:0] a, output logic [15:0] r);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    r = rdata;
  endtask

  // Waits for the output to rise, then counts the cycles it stays high.
  task automatic hi_width(output int wd);
    int k;
    k = 0;
    wd = 0;
    @(negedge clk);
    while (tpin !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    while (tpin === 1'b1 && wd < 3000) begin
      @(negedge clk);
      wd++;
    end
  endtask

  task automatic setup(input logic [15:0] pre, input logic [15:0] per, input logic [15:0] sec,
                       input logic [15:0] outc, input logic [15:0] mode);
    wr_reg(`OFF_MODE_CTRL, 16'h0000);
    wr_reg(`OFF_PRESCALE, pre);
    wr_reg(`OFF_PERIOD, per);
    wr_reg(`OFF_SECONDARY, sec);
    wr_reg(`OFF_OUT_CTRL, outc);
    wr_reg(`OFF_MODE_CTRL, mode);
  endtask

  task automatic print_verdict();
    $display("checks %0d, failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) rd_q <= rd;

  always @(negedge clk) begin
    if (rd_q && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
    if (pirq === 1'b1) n_pirq++;
    if (sirq === 1'b1) n_sirq++;
  end

  initial begin
    // The tests need about 70k cycles, so 90k cycles is a safe limit.
    #450000;
    n_fail++;
    print_verdict();
  end

  initial begin
    {rst, wr, rd, addr, wdata} = '0;
    rst = 1'b1;
    seed = 32'd22483;
    {n_fail, num_checks, n_pirq, n_sirq} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped place and read-only counter.
    rd_reg(`OFF_COUNTER, 16'h0000);
    rd_reg(`OFF_MODE_CTRL, 16'h0000);
    v = 16'(xs());
    wr_reg(8'h1C, v);
    rd_reg(8'h1C, 16'h0000);
    wr_reg(`OFF_PERIOD, v);
    rd_reg(`OFF_PERIOD, v);
    wr_reg(`OFF_COUNTER, 16'h1234);
    rd_reg(`OFF_COUNTER, 16'h0000);
    // Event counting for every edge code, with a glitch each time.
    for (int i = 0; i < 4; i++) begin
      setup(16'({codes[i], 4'h3}), 16'h0100, 16'h0001, 16'h0000, 16'h000C);
      n = int'(xs() % 4) + 1;
      i_src.pulse(1, 6);
      repeat (n) i_src.pulse(3 + int'(xs() % 3), 5);
      repeat (4) @(posedge clk);
      rd_reg(`OFF_COUNTER, 16'(n * mult[i]));
    end
    // Event counting clears on period match.
    setup(16'h0013, 16'h0003, 16'h0001, 16'h0000, 16'h000C);
    n_pirq = 0;
    repeat (4) i_src.pulse(3, 5);
    repeat (4) @(posedge clk);
    rd_reg(`OFF_COUNTER, 16'h0000);
    chk(n_pirq, 1);
    rd_reg(`OFF_MODE_CTRL, 16'h000C);
    i_src.pulse(3, 8);
    rd_reg(`OFF_COUNTER, 16'h0001);
    // Overflow on wrap with a maximum period, then cleared by software.
    setup(16'h0000, `COUNT_MAX, 16'h0001, 16'h0000, 16'h000C);
    repeat (65556) @(posedge clk);
    rd_reg(`OFF_MODE_CTRL, 16'h000D);
    repeat (50) @(posedge clk);
    rd_reg(`OFF_MODE_CTRL, 16'h000D);
    wr_reg(`OFF_MODE_CTRL, 16'h000C);
    rd_reg(`OFF_MODE_CTRL, 16'h000C);
    // Square wave toggles every period plus one counts.
    setup(16'h0000, 16'h0004, 16'h0001, 16'h0003, 16'h000C);
    repeat (2) begin
      hi_width(w);
      chk(w, 5);
    end
    setup(16'h0002, 16'h0001, 16'h0001, 16'h0003, 16'h000C);
    hi_width(w);
    chk(w, 2 * `DIV_SEL2);
    // Software one-shot, both compare orders; the counter keeps running.
    for (int i = 0; i < 2; i++) begin
      setup(16'h0000, i ? 16'h0003 : 16'h000C, i ? 16'h000C : 16'h0003,
            16'h0021, 16'h0004);
      fork
        wr_reg(`OFF_OUT_CTRL, 16'h0061);
        hi_width(w);
      join
      chk(w, 9);
      rd_val(`OFF_COUNTER, v);
      rd_val(`OFF_COUNTER, v2);
      chk(v2 != v, 1);
    end
    wr_reg(`OFF_MODE_CTRL, 16'h0000);
    rd_reg(`OFF_COUNTER, 16'h0000);
    // External one-shot for the fall, rise and both-edge codes; a late edge is ignored.
    for (int i = 0; i < 3; i++) begin
      setup(16'({codes[i], 4'h0}), 16'h0014, 16'h0005, 16'h0021, 16'h0004);
      fork
        i_src.pulse(4, 40);
        hi_width(w);
      join
      chk(w, 15);
    end
    // Restart capture on rising edges at an eight-clock count rate.
    wr_reg(`OFF_MODE_CTRL, 16'h0000);
    wr_reg(`OFF_OUT_CTRL, 16'h0000);
    wr_reg(`OFF_PRESCALE, 16'h0011);
    wr_reg(`OFF_CAP_CTRL, 16'h0001);
    wr_reg(`OFF_MODE_CTRL, 16'h0008);
    n_sirq = 0;
    repeat (3) begin
      i_src.pulse(24, 20);
      i_src.pulse(3, 33);
    end
    rd_val(`OFF_SECONDARY, v);
    chk(v inside {16'h0009, 16'h000A}, 1);
    chk(n_sirq, 3);
    print_verdict();
  end
endmodule
`default_nettype wire

//--- src/count_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cfg.svh"
module count_prescaler
  import timer16_pkg::*;
#(
  parameter int DIV0 = `DIV_SEL0,
  parameter int DIV1 = `DIV_SEL1,
  parameter int DIV2 = `DIV_SEL2
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Control.
  input  wire logic       run,
  input  wire logic [1:0] sel,
  // Count clock enable.
  output logic            tick
);
  if (DIV0 < 1 || DIV1 < 1 || DIV2 < 1 || DIV2 > 65535) begin : g_bad_div
    $error("Prescaler divide ratios must lie between 1 and 65535.");
  end

  logic [15:0] div_cnt;
  logic [15:0] limit;

  always_comb begin
    unique case (sel)
      2'h0:    limit = 16'(DIV0 - 1);
      2'h1:    limit = 16'(DIV1 - 1);
      default: limit = 16'(DIV2 - 1);
    endcase
  end

  assign tick = run && (div_cnt >= limit);

  // Divider restarts when the timer stops so a start is one period from a tick.
  always_ff @(posedge clk) begin
    if (rst || !run || tick) begin
      div_cnt <= `RST_WORD16;
    end else begin
      div_cnt <= div_cnt + `COUNT_ONE;
    end
  end
endmodule
`default_nettype wire

//--- src/edge_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cfg.svh"
module edge_filter
  import timer16_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Sampled input and detected edge.
  edge_if.filt      e
);
  logic samp_new;
  logic samp_old;
  logic lvl;
  logic agree;

  // A level counts only after two consecutive equal samples.
  assign agree   = e.sample_en && (samp_new == samp_old) && (samp_new != lvl);
  assign e.level = lvl;
  assign e.edge_hit = agree && edge_match(e.edge_sel, samp_new, !samp_new);

  always_ff @(posedge clk) begin
    if (rst) begin
      samp_new <= 1'b0;
      samp_old <= 1'b0;
    end else if (e.sample_en) begin
      samp_new <= e.pin;
      samp_old <= samp_new;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lvl <= 1'b0;
    end else if (agree) begin
      lvl <= samp_new;
    end
  end
endmodule
`default_nettype wire

//--- src/edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface edge_if;
  import timer16_pkg::*;
  logic      sample_en;
  logic      pin;
  edge_sel_e edge_sel;
  logic      edge_hit;
  logic      level;

  modport filt (input sample_en, input pin, input edge_sel, output edge_hit, output level);
  modport user (output sample_en, output pin, output edge_sel, input edge_hit, input level);
endinterface
`default_nettype wire

//--- src/timer16_capture_event_oneshot.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cfg.svh"
module timer16_capture_event_oneshot
  import timer16_pkg::*;
#(
  parameter int DIV0 = `DIV_SEL0,
  parameter int DIV1 = `DIV_SEL1,
  parameter int DIV2 = `DIV_SEL2
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port.
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // Pins.
  input  wire logic        trigger_input_pin,
  output logic             timer_output_pin,
  // Interrupt requests.
  output logic             period_match_irq,
  output logic             secondary_match_irq
);
  // Software-visible state.
  op_mode_e    op_mode;
  logic [1:0]  clk_sel;
  edge_sel_e   edge_sel;
  logic        sec_is_capture;
  logic        output_enable_bit;
  logic        toggle_on_period_match_bit;
  logic        oneshot_enable;
  logic        overflow_flag;
  logic [15:0] period_compare_capture;
  logic [15:0] secondary_compare_capture;
  logic [15:0] main_counter;

  // Internal state.
  logic        out_ff;
  logic        pulse_busy;
  logic        cap_pending;

  // Decoded control.
  logic running;
  logic event_mode;
  logic tick;
  logic edge_hit;
  logic count_en;
  logic cap_event;
  logic soft_trig;
  logic ext_trig;
  logic restart;
  logic per_hit;
  logic sec_hit;
  logic sec_first;
  logic wr_mode;
  logic wr_pre;
  logic wr_cap;
  logic wr_out;
  logic wr_per;
  logic wr_sec;

  edge_if ein ();

  assign running    = (op_mode != OP_STOP);
  assign event_mode = (clk_sel == `CLKSEL_EVENT);

  count_prescaler #(
    .DIV0 (DIV0),
    .DIV1 (DIV1),
    .DIV2 (DIV2)
  ) u_prescaler (
    .clk  (clk),
    .rst  (rst),
    .run  (running && !event_mode),
    .sel  (clk_sel),
    .tick (tick)
  );

  // Event mode samples every system clock, capture modes on the count clock.
  assign ein.sample_en = running && (event_mode ? 1'b1 : tick);
  assign ein.pin       = trigger_input_pin;
  assign ein.edge_sel  = edge_sel;
  assign edge_hit      = ein.edge_hit;

  edge_filter u_filter (
    .clk (clk),
    .rst (rst),
    .e   (ein.filt)
  );

  // Register write decode.
  assign wr_mode = wr && (addr == `OFF_MODE_CTRL);
  assign wr_pre  = wr && (addr == `OFF_PRESCALE);
  assign wr_cap  = wr && (addr == `OFF_CAP_CTRL);
  assign wr_out  = wr && (addr == `OFF_OUT_CTRL);
  assign wr_per  = wr && (addr == `OFF_PERIOD);
  assign wr_sec  = wr && (addr == `OFF_SECONDARY);

  // Count enable: valid edges in event mode, prescaler ticks otherwise.
  assign count_en  = running && (event_mode ? edge_hit : tick);
  assign cap_event = (op_mode == OP_RESTART) && !event_mode && edge_hit;
  assign soft_trig = wr_out && wdata[`OUT_SOFT_BIT] && oneshot_enable && running;
  assign ext_trig  = running && oneshot_enable && !event_mode && edge_hit
                     && !pulse_busy;
  assign restart   = cap_event || ext_trig || soft_trig;
  assign per_hit   = count_en && (main_counter == period_compare_capture);
  assign sec_hit   = count_en && (main_counter == secondary_compare_capture)
                     && !sec_is_capture;
  assign sec_first = (secondary_compare_capture < period_compare_capture);

  // Control registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      op_mode <= OP_STOP;
    end else if (wr_mode) begin
      op_mode <= op_mode_e'(wdata[`MODE_OP_HI:`MODE_OP_LO]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_sel  <= 2'h0;
      edge_sel <= EDGE_FALL;
    end else if (wr_pre) begin
      clk_sel  <= wdata[`PRE_CLK_HI:`PRE_CLK_LO];
      edge_sel <= edge_sel_e'(wdata[`PRE_EDGE_HI:`PRE_EDGE_LO]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sec_is_capture <= 1'b0;
    end else if (wr_cap) begin
      sec_is_capture <= wdata[`CAP_SEC_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      output_enable_bit          <= 1'b0;
      toggle_on_period_match_bit <= 1'b0;
      oneshot_enable             <= 1'b0;
    end else if (wr_out) begin
      output_enable_bit          <= wdata[`OUT_EN_BIT];
      toggle_on_period_match_bit <= wdata[`OUT_TGL_PER_BIT];
      oneshot_enable             <= wdata[`OUT_ONESHOT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      period_compare_capture <= `RST_WORD16;
    end else if (wr_per) begin
      period_compare_capture <= wdata;
    end
  end

  // Capture takes priority over a software write in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      secondary_compare_capture <= `RST_WORD16;
    end else if (cap_event && sec_is_capture) begin
      secondary_compare_capture <= main_counter;
    end else if (wr_sec) begin
      secondary_compare_capture <= wdata;
    end
  end

  // Main counter.
  always_ff @(posedge clk) begin
    if (rst || !running) begin
      main_counter <= `RST_WORD16;
    end else if (restart) begin
      main_counter <= `RST_WORD16;
    end else if (count_en) begin
      if (op_mode == OP_MATCH && main_counter == period_compare_capture) begin
        main_counter <= `RST_WORD16;
      end else begin
        main_counter <= main_counter + `COUNT_ONE;
      end
    end
  end

  // Overflow is sticky; a wrap in the clearing cycle wins over the clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_flag <= 1'b0;
    end else if (count_en && !restart && main_counter == `COUNT_MAX) begin
      overflow_flag <= 1'b1;
    end else if (wr_mode && !wdata[`MODE_OVF_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  // Capture interrupt follows at the next count clock.
  always_ff @(posedge clk) begin
    if (rst || !running) begin
      cap_pending <= 1'b0;
    end else if (cap_event && sec_is_capture) begin
      cap_pending <= 1'b1;
    end else if (tick) begin
      cap_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      period_match_irq    <= 1'b0;
      secondary_match_irq <= 1'b0;
    end else begin
      period_match_irq    <= per_hit && !restart;
      secondary_match_irq <= (sec_hit && !restart) || (cap_pending && tick);
    end
  end

  // One-shot activity window.
  always_ff @(posedge clk) begin
    if (rst || !running || !oneshot_enable) begin
      pulse_busy <= 1'b0;
    end else if (ext_trig || soft_trig) begin
      pulse_busy <= 1'b1;
    end else if (pulse_busy && ((sec_first && per_hit) || (!sec_first && sec_hit))) begin
      pulse_busy <= 1'b0;
    end
  end

  // Output flip-flop.
  always_ff @(posedge clk) begin
    if (rst || !running) begin
      out_ff <= 1'b0;
    end else if (oneshot_enable) begin
      if (pulse_busy && !restart && sec_hit) begin
        out_ff <= sec_first;
      end else if (pulse_busy && !restart && per_hit) begin
        out_ff <= !sec_first;
      end
    end else if (toggle_on_period_match_bit && op_mode == OP_MATCH && per_hit) begin
      out_ff <= !out_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_pin <= output_enable_bit && out_ff;
    end
  end

  // Read port; unmapped addresses read zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= `RST_WORD16;
    end else if (rd) begin
      unique case (addr)
        `OFF_MODE_CTRL: rdata <= {12'h000, op_mode, 1'b0, overflow_flag};
        `OFF_PRESCALE:  rdata <= {10'h000, edge_sel, 2'h0, clk_sel};
        `OFF_CAP_CTRL:  rdata <= {15'h0000, sec_is_capture};
        `OFF_OUT_CTRL:  rdata <= {10'h000, oneshot_enable, 3'h0,
                                  toggle_on_period_match_bit, output_enable_bit};
        `OFF_PERIOD:    rdata <= period_compare_capture;
        `OFF_SECONDARY: rdata <= secondary_compare_capture;
        `OFF_COUNTER:   rdata <= main_counter;
        default:        rdata <= `RST_WORD16;
      endcase
    end else begin
      rdata <= `RST_WORD16;
    end
  end

  // Checks.
  property p_restart_capture;
    @(posedge clk) disable iff (rst)
    (cap_event && sec_is_capture && running) |=>
      (secondary_compare_capture == $past(main_counter)) && (main_counter == `RST_WORD16);
  endproperty
  a_restart_capture: assert property (p_restart_capture)
    else $error("Restart capture did not store and clear.");
  property p_bad_edge;
    @(posedge clk) disable iff (rst)
    (edge_sel == EDGE_BAD) |-> !edge_hit;
  endproperty
  a_bad_edge: assert property (p_bad_edge)
    else $error("Prohibited edge code produced an edge.");
  property p_match_clear;
    @(posedge clk) disable iff (rst)
    (op_mode == OP_MATCH && count_en && !restart && main_counter == period_compare_capture)
      |=> (main_counter == `RST_WORD16) && period_match_irq;
  endproperty
  a_match_clear: assert property (p_match_clear)
    else $error("Period match did not clear counter with irq.");
  property p_ovf_cause;
    @(posedge clk) disable iff (rst)
    $rose(overflow_flag) |-> ($past(main_counter) == 16'hFFFF) && (main_counter == 16'h0000);
  endproperty
  a_ovf_cause: assert property (p_ovf_cause)
    else $error("Overflow set without wrap from maximum.");

  property p_square_toggle;
    @(posedge clk) disable iff (rst)
    (running && !oneshot_enable && toggle_on_period_match_bit && op_mode == OP_MATCH
     && per_hit && !wr_mode) |=> (out_ff != $past(out_ff))
      ##1 (timer_output_pin == ($past(output_enable_bit) && $past(out_ff)));
  endproperty
  a_square_toggle: assert property (p_square_toggle)
    else $error("Square wave output did not invert on match.");
  property p_soft_start;
    @(posedge clk) disable iff (rst)
    (soft_trig && !wr_mode) |=> (main_counter == 16'h0000) && pulse_busy;
  endproperty
  a_soft_start: assert property (p_soft_start)
    else $error("Soft trigger did not clear and start.");

  property p_ignore_retrigger;
    @(posedge clk) disable iff (rst)
    (pulse_busy && edge_hit && op_mode == OP_FREE && !soft_trig && !wr_mode)
      |=> main_counter == $past(main_counter) + {15'h0000, $past(count_en)};
  endproperty
  a_ignore_retrigger: assert property (p_ignore_retrigger)
    else $error("External trigger accepted during a pulse.");

  property p_free_count;
    @(posedge clk) disable iff (rst)
    (op_mode == OP_FREE && count_en && !restart && !wr_mode)
      |=> main_counter == $past(main_counter) + `COUNT_ONE;
  endproperty
  a_free_count: assert property (p_free_count)
    else $error("Running counter failed to increment.");

  property p_oneshot_active;
    @(posedge clk) disable iff (rst)
    (pulse_busy && oneshot_enable && sec_first && sec_hit && !restart && !wr_mode && !wr_out)
      |=> out_ff ##1 timer_output_pin == $past(output_enable_bit);
  endproperty
  a_oneshot_active: assert property (p_oneshot_active)
    else $error("One-shot output did not go active at secondary match.");
endmodule
`default_nettype wire

//--- src/timer16_cfg.svh
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

// Register byte addresses.
`define OFF_MODE_CTRL     8'h00
`define OFF_PRESCALE      8'h04
`define OFF_CAP_CTRL      8'h08
`define OFF_OUT_CTRL      8'h0C
`define OFF_PERIOD        8'h10
`define OFF_SECONDARY     8'h14
`define OFF_COUNTER       8'h18

// Mode control register fields.
`define MODE_OVF_BIT      0
`define MODE_OP_LO        2
`define MODE_OP_HI        3

// Prescaler mode register fields.
`define PRE_CLK_LO        0
`define PRE_CLK_HI        1
`define PRE_EDGE_LO       4
`define PRE_EDGE_HI       5
`define CLKSEL_EVENT      2'h3

// Capture/compare control register fields.
`define CAP_SEC_BIT       0

// Output control register fields.
`define OUT_EN_BIT        0
`define OUT_TGL_PER_BIT   1
`define OUT_ONESHOT_BIT   5
`define OUT_SOFT_BIT      6

// Reset values and constants.
`define RST_WORD16        16'h0000
`define RST_BYTE          8'h00
`define COUNT_MAX         16'hFFFF
`define COUNT_ONE         16'h0001

// Prescaler divide ratios.
`define DIV_SEL0          2
`define DIV_SEL1          8
`define DIV_SEL2          32

`endif

//--- src/timer16_pkg.sv
package timer16_pkg;

  typedef enum logic [1:0] {
    OP_STOP,
    OP_FREE,
    OP_RESTART,
    OP_MATCH
  } op_mode_e;

  typedef enum logic [1:0] {
    EDGE_FALL,
    EDGE_RISE,
    EDGE_BAD,
    EDGE_BOTH
  } edge_sel_e;

  // Selects the qualifying edge for a given edge-select code.
  function automatic logic edge_match(input edge_sel_e sel, input logic rise,
                                      input logic fall);
    logic r;
    r = 1'b0;
    unique case (sel)
      EDGE_FALL: r = fall;
      EDGE_RISE: r = rise;
      EDGE_BAD:  r = 1'b0;
      EDGE_BOTH: r = rise | fall;
    endcase
    return r;
  endfunction

endpackage
